// file: logic/register_bit_address_generator.v
`timescale 1ns/1ps
`include "bit_addr_defines.vh"

module register_bit_address_generator #(
    parameter PW = `PTR_WIDTH,
    parameter SW = `SRC_WIDTH
) (
    input wire mclk,
    input wire reset_n,
    input wire start,
    input wire bit_set_instr,
    input wire bit_pair_test_instr,
    input wire [1:0] mode,
    input wire legacy_compat_mode,
    input wire circularEn,
    input wire pointerLoad,
    input wire [PW-1:0] pointerLoadValue,
    input wire [15:0] buffer_start_value,
    input wire [15:0] temp_index_reg,
    input wire [PW-1:0] extended_aux_zero,
    input wire [SW-1:0] accumulator_three,
    output reg [PW-1:0] extended_pointer,
    output reg [PW-1:0] bitAddrOut,
    output reg [SW-1:0] result,
    output reg resultWrite,
    output reg test_flag_one,
    output reg test_flag_two,
    output reg done
);
    // ********************************
    // Address arithmetic
    // ********************************
    wire [PW-1:0] bitAddr;
    wire [PW-1:0] modPointer;
    wire pairOp;
    wire [`BITPOS_WIDTH-1:0] pos;
    wire [`BITPOS_WIDTH-1:0] posHigh;
    wire accepted;
    reg [PW-1:0] next_pointer;
    reg [PW-1:0] next_bitAddrOut;
    reg [SW-1:0] next_result;
    reg next_resultWrite;
    reg next_flagOne;
    reg next_flagTwo;
    reg next_done;

    assign pairOp = bit_pair_test_instr;
    assign accepted = start & (bit_set_instr | bit_pair_test_instr);
    // Only low bits pick a bit within the register
    assign pos = bitAddr[`BITPOS_WIDTH-1:0];
    assign posHigh = pos + 6'h01;

    bit_addr_calc #(
        .PW(PW)
    ) calc (
        .mode(mode),
        .pairOp(pairOp),
        .legacy_compat_mode(legacy_compat_mode),
        .circularEn(circularEn),
        .extended_pointer(extended_pointer),
        .buffer_start_value(buffer_start_value),
        .temp_index_reg(temp_index_reg),
        .extended_aux_zero(extended_aux_zero),
        .bitAddr(bitAddr),
        .modPointer(modPointer)
    );

    // Bit read with out-of-range position reading zero
    function pick;
        input [SW-1:0] src;
        input [`BITPOS_WIDTH-1:0] p;
        begin
            if (p < SW)
                pick = src[p];
            else
                pick = 1'b0;
        end
    endfunction

    // Set one bit; positions past the top leave the register unchanged
    function [SW-1:0] setBit;
        input [SW-1:0] src;
        input [`BITPOS_WIDTH-1:0] p;
        begin
            setBit = src | ({{(SW-1){1'b0}}, 1'b1} << p);
        end
    endfunction

    // ********************************
    // Operation and pointer update
    // ********************************
    // Single-cycle: pointer, plus flags (pair test) or result (bit set), update on the accept edge
    always @*
    begin
        // Strobes default low, levels hold until the next operation (the pointer also changes on a pointer load)
        next_pointer = extended_pointer;
        next_bitAddrOut = bitAddrOut;
        next_result = result;
        next_resultWrite = 1'b0;
        next_flagOne = test_flag_one;
        next_flagTwo = test_flag_two;
        next_done = accepted;
        if (accepted)
        begin
            next_pointer = modPointer;
            next_bitAddrOut = bitAddr;
            if (pairOp)
            begin
                next_flagOne = pick(accumulator_three, pos);
                next_flagTwo = pick(accumulator_three, posHigh);
            end
            else
            begin
                next_result = setBit(accumulator_three, pos);
                next_resultWrite = 1'b1;
            end
        end
        else if (pointerLoad)
        begin
            // Load loses to an operation in the same cycle
            next_pointer = pointerLoadValue;
        end
    end

    // ********************************
    // Output registers
    // ********************************
    // One flop per output, so no output sees the adder paths directly
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            extended_pointer <= `PTR_RESET;
        end
        else
        begin
            extended_pointer <= next_pointer;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bitAddrOut <= `PTR_RESET;
        end
        else
        begin
            bitAddrOut <= next_bitAddrOut;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result <= `SRC_RESET;
        end
        else
        begin
            result <= next_result;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resultWrite <= 1'b0;
        end
        else
        begin
            resultWrite <= next_resultWrite;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            test_flag_one <= 1'b0;
        end
        else
        begin
            test_flag_one <= next_flagOne;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            test_flag_two <= 1'b0;
        end
        else
        begin
            test_flag_two <= next_flagTwo;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= next_done;
        end
    end
endmodule

// file: pkg/bit_addr_defines.vh
`ifndef BIT_ADDR_DEFINES_VH
`define BIT_ADDR_DEFINES_VH

// Operand forms (mode input encoding)
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_ADD_IDX 2'h2
`define MODE_POST_SUB_IDX 2'h3

// Widths
`define PTR_WIDTH 23
`define PTR_LOW_WIDTH 16
`define SRC_WIDTH 40
`define BITPOS_WIDTH 6

// Step sizes of pre-modified pointers
`define STEP_ONE_BIT 23'h00_0001
`define STEP_TWO_BIT 23'h00_0002

// Reset values
`define PTR_RESET 23'h00_0000
`define SRC_RESET 40'h00_0000_0000

// Sequencer states
`define ST_IDLE 2'h0
`define ST_ACCESS 2'h1

`endif

// file: logic/bit_addr_calc.v
`timescale 1ns/1ps
`include "bit_addr_defines.vh"

// Combinational pointer arithmetic: effective address and updated pointer
module bit_addr_calc #(
    parameter PW = 23
) (
    input wire [1:0] mode,
    input wire pairOp,
    input wire legacy_compat_mode,
    input wire circularEn,
    input wire [PW-1:0] extended_pointer,
    input wire [15:0] buffer_start_value,
    input wire [15:0] temp_index_reg,
    input wire [PW-1:0] extended_aux_zero,
    output reg [PW-1:0] bitAddr,
    output reg [PW-1:0] modPointer
);
    reg [PW-1:0] step;
    reg [PW-1:0] index;
    reg [PW-1:0] base;
    reg [PW-1:0] bsaExt;

    always @*
    begin
        step = pairOp ? `STEP_TWO_BIT : `STEP_ONE_BIT;
        // Index source chosen by compatibility mode
        index = legacy_compat_mode ? extended_aux_zero
                : {{(PW-16){1'b0}}, temp_index_reg};
        // Buffer start sign-extended before it joins the address
        bsaExt = {{(PW-16){buffer_start_value[15]}}, buffer_start_value};
        case (mode)
            `MODE_PRE_INC:
            begin
                modPointer = extended_pointer + step;
                base = modPointer;
            end
            `MODE_PRE_DEC:
            begin
                modPointer = extended_pointer - step;
                base = modPointer;
            end
            `MODE_POST_ADD_IDX:
            begin
                modPointer = extended_pointer + index;
                base = extended_pointer;
            end
            `MODE_POST_SUB_IDX:
            begin
                modPointer = extended_pointer - index;
                base = extended_pointer;
            end
            default:
            begin
                modPointer = extended_pointer;
                base = extended_pointer;
            end
        endcase
        bitAddr = circularEn ? base + bsaExt : base;
    end
endmodule

// file: testbench/bit_addr_checker.sv
`timescale 1ns/1ps
module bit_addr_checker (
    input wire mclk, reset_n, start, bit_set_instr, bit_pair_test_instr,
    input wire legacy_compat_mode, circularEn, done, resultWrite,
    input wire test_flag_one, test_flag_two, input wire [1:0] mode,
    input wire [15:0] temp_index_reg, input wire [39:0] accumulator_three,
    input wire [22:0] extended_aux_zero, extended_pointer, bitAddrOut,
    input wire [39:0] result, input wire [15:0] buffer_start_value,
    input wire pointerLoad, input wire [22:0] pointerLoadValue
);
    wire pair = bit_pair_test_instr;
    wire go = start && (bit_set_instr || pair);
    wire [22:0] ix = legacy_compat_mode ? extended_aux_zero :
        {7'h0, temp_index_reg};
    wire [22:0] d = mode[1] ? ix : pair ? 23'h2 : 23'h1;
    wire [22:0] up = mode[0] ? extended_pointer - d : extended_pointer + d;
    wire [22:0] base = mode[1] ? extended_pointer : up;
    wire [5:0] b = bitAddrOut[5:0];
    wire [22:0] sx = {{7{buffer_start_value[15]}}, buffer_start_value};
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_done_pulse: assert property (go |=> done) else $error("no done");
    a_no_done: assert property (!go |=> !done) else $error("stray done");
    a_no_write: assert property (!go |=> !resultWrite) else $error("write");
    a_ptr_step:
        assert property (go |=> extended_pointer == $past(up))
            else $error("ptr");
    a_bit_addr:
        assert property (go && !circularEn |=> bitAddrOut == $past(base))
            else $error("addr");
    a_pair_flags:
        assert property (go && pair |=> b > 38 || {test_flag_two,
            test_flag_one} == 2'($past(accumulator_three) >> b))
            else $error("flags");
    a_flag_hold:
        assert property (go && !pair |=>
            $stable({test_flag_two, test_flag_one})) else $error("hold");
    a_set_bit:
        assert property (go && !pair |=> resultWrite && (b > 39 ||
            result == ($past(accumulator_three) | 40'h1 << b)))
            else $error("set");
    a_circ_addr:
        assert property (go && circularEn |=> bitAddrOut == $past(base + sx))
            else $error("circular addr");
    a_ptr_load:
        assert property (!go && pointerLoad |=> extended_pointer ==
            $past(pointerLoadValue)) else $error("ptr load");
    a_ptr_hold:
        assert property (!go && !pointerLoad |=> $stable(extended_pointer))
            else $error("ptr hold");
endmodule
bind register_bit_address_generator bit_addr_checker chk (.*);

// file: testbench/test_register_bit_address_generator.sv
`timescale 1ns/1ps
module test_register_bit_address_generator;
    reg mclk = 0, reset_n = 0, start = 0, bit_set_instr = 0, circularEn = 0;
    reg bit_pair_test_instr = 0, legacy_compat_mode = 0, pointerLoad = 1;
    reg [1:0] mode = 0;
    reg [15:0] buffer_start_value = 0, temp_index_reg = 0;
    reg [22:0] pointerLoadValue = 0, extended_aux_zero = 0, p = 0, s, ad;
    reg [39:0] accumulator_three = 0, r;
    reg [5:0] b, t;
    reg [88:0] n, q[$];
    wire [22:0] extended_pointer, bitAddrOut;
    wire [39:0] result;
    wire resultWrite, test_flag_one, test_flag_two, done;
    int err_total = 0, samples_checked = 0;
    register_bit_address_generator dut (.*);
    initial forever #2.5 mclk = ~mclk;
    task chk(input string w, input logic [39:0] e, g);
        samples_checked++;
        err_total += e !== g;
        if (e !== g)
            $display("Error %s exp %h got %h", w, e, g);
    endtask
    task chk_pointer(input logic [22:0] e, g);
        chk("pointer", e, g);
    endtask
    task chk_address(input logic [22:0] e, g);
        chk("address", e, g);
    endtask
    task chk_flags(input logic [1:0] e, g);
        chk("flags", e, g);
    endtask
    task chk_result(input logic [39:0] e, g);
        chk("result", e, g);
    endtask
    task give_verdict;
        $display("%0d checked %0d errors", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task op(input [5:0] c);
        @(posedge mclk) #1;
        {bit_set_instr, circularEn, legacy_compat_mode, bit_pair_test_instr,
            mode} = c;
        start = 1;
        {temp_index_reg, buffer_start_value} = $urandom;
        accumulator_three = 40'({$urandom, $urandom});
        {pointerLoadValue, extended_aux_zero} = 46'({$urandom, $urandom});
        pointerLoad = 1'($urandom);
        r = accumulator_three;
        // Load only lands when no operation is taken
        if (!(c[5] || c[2]))
            p = pointerLoad ? pointerLoadValue : p;
        else
        begin
            s = c[2] ? 23'h2 : 23'h1;
            if (mode[1])
                s = c[3] ? extended_aux_zero : {7'h0, temp_index_reg};
            if (!mode[1])
                p = mode[0] ? p - s : p + s;
            ad = c[4] ? p + {{7{buffer_start_value[15]}},
                buffer_start_value} : p;
            if (mode[1])
                p = mode[0] ? p - s : p + s;
            b = ad[5:0];
            t = b + 6'h1;
            q.push_back({c[2], t < 40 && r[t], b < 40 && r[b],
                r | 40'(b < 40) << b, ad, p});
        end
    endtask
    // Falling edge keeps clear of back-to-back updates
    always @(negedge mclk)
        if (done === 1'b1)
        begin
            n = q.pop_front();
            chk_pointer(n[22:0], extended_pointer);
            chk_address(n[45:23], bitAddrOut);
            if (n[88])
                chk_flags(n[87:86], {test_flag_two, test_flag_one});
            else
                chk_result(n[85:46], result);
        end
    initial
    begin
        void'($urandom(5187));
        repeat (3) @(posedge mclk);
        #1 reset_n = 1;
        for (int i = 0; i < 64; i++)
            op(i[5:0]);
        $display("form sweep done");
        repeat (300) op(6'($urandom));
        @(posedge mclk) #1 start = 0;
        repeat (3) @(posedge mclk);
        chk("pending", 0, q.size());
        $display("random run done");
        give_verdict;
    end
    initial
    begin
        #4000 err_total++;
        give_verdict;
    end
endmodule
